// ---- common/dsp_mac_pkg.sv ----
// Purpose: Shared constants and types for the multiply-accumulate block.
// Assumes: One clock, 32-bit register port with word-aligned byte offsets.
// Notes:   Lane widths follow the four arithmetic modes of the block.
package dsp_mac_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int A_W     = 19;
	localparam int B_W     = 18;
	localparam int ACC_W   = 48;
	localparam int SHIFT_W = 4;
	localparam int CNT_W   = 16;

	// Per-mode lane geometry: operand widths and adder widths.
	localparam int SGL_RW  = 48;
	localparam int DUAL_RW = 24;
	localparam int DA0_W   = 11;
	localparam int DB0_W   = 10;
	localparam int DA1_W   = 8;
	localparam int DB1_W   = 8;
	localparam int QUAD_RW = 12;
	localparam int QA0_W   = 7;
	localparam int QB0_W   = 6;
	localparam int QN_W    = 4;
	localparam int QUAD_N  = 4;

	// Floating-point format.
	localparam int BF_W    = 16;
	localparam int BF_MAN  = 7;
	localparam int BF_BIAS = 127;
	localparam int BF_EMAX = 255;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] RLO_OFS  = 8'h08;
	localparam logic [ADDR_W-1:0] RHI_OFS  = 8'h0C;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MODE_SINGLE, MODE_DUAL, MODE_QUAD, MODE_FLOAT} mode_t;
	typedef enum logic [1:0] {OP_BYPASS, OP_ADD, OP_SUB, OP_ACC} op_t;

	// Control word: mode [1:0], signed [2], op [4:3], shift [8:5].
	typedef struct packed {
		logic [SHIFT_W-1:0] shift;
		op_t                op;
		logic               sgn;
		mode_t              mode;
	} ctrl_t;

	// Operands driven by the fabric, taken together on each request.
	typedef struct packed {
		logic [A_W-1:0]   a;
		logic [B_W-1:0]   b;
		logic [ACC_W-1:0] c;
	} operand_t;

	localparam ctrl_t CTRL_RST = '{shift: 4'h0, op: OP_BYPASS, sgn: 1'h1, mode: MODE_SINGLE};

endpackage

// ---- logic/dsp_mac_lane.sv ----
// Purpose: One integer lane: multiply, optional add/subtract, right shift.
// Assumes: Purely combinational; the caller registers the results.
// Notes:   Product is resized to the adder width, so wide products truncate.
`timescale 1ns/10ps
module dsp_mac_lane
	import dsp_mac_pkg::*;
#(
	parameter int AW = 19,
	parameter int BW = 18,
	parameter int RW = 48
)
(
	input  wire logic [AW-1:0]      a_i,      // First operand.
	input  wire logic [BW-1:0]      b_i,      // Second operand.
	input  wire logic [RW-1:0]      addend_i, // Addend or running sum.
	input  wire op_t                op_i,     // Adder operation.
	input  wire logic               signed_i, // Two's complement operands.
	input  wire logic [SHIFT_W-1:0] shift_i,  // Right shift amount.
	output logic      [RW-1:0]      sum_o,    // Unshifted adder output.
	output logic      [RW-1:0]      result_o  // Shifted lane result.
);

	logic signed [AW:0]      ax;
	logic signed [BW:0]      bx;
	logic signed [AW+BW+1:0] prod;
	logic        [RW-1:0]    prod_rw;

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	// A ninth-style guard bit carries the sign, so one signed multiplier
	// serves both signed and unsigned operands.
	always_comb
	begin
		ax      = $signed({signed_i & a_i[AW-1], a_i});                // [RULE9]
		bx      = $signed({signed_i & b_i[BW-1], b_i});                // [RULE9]
		prod    = ax * bx;
		prod_rw = RW'(prod);                                           // [RULE5]
		case (op_i)
			OP_BYPASS: sum_o = prod_rw;                                  // [RULE12]
			OP_SUB:    sum_o = addend_i - prod_rw;                       // [RULE8]
			default:   sum_o = addend_i + prod_rw;                       // [RULE8]
		endcase
		if (signed_i)
		begin
			result_o = RW'($signed(sum_o) >>> shift_i);                  // [RULE7]
		end
		else
		begin
			result_o = sum_o >> shift_i;                                 // [RULE7]
		end
	end

endmodule // dsp_mac_lane

// ---- logic/dsp_mac.sv ----
// Purpose: Configurable multiply-accumulate block with four arithmetic modes.
// Assumes: Operands synchronous to clock_i; control set over the register port.
// Notes:   One pipeline stage; the result stands from the cycle after en_i.
//
// Overview of operation
// [RULE1] Four modes: single, dual, quad integer lanes, and floating point.
// [RULE2] Single mode: one 19x18 product with a 48-bit adder/subtractor.
// [RULE3] Dual mode: 11x10 and 8x8 products, each with a 24-bit adder.
// [RULE4] Quad mode: one 7x6 and three 4x4 products, four 12-bit adders.
// [RULE5] The quad 7x6 product is cut to its low 12 bits.
// [RULE6] Float mode: one fused multiply-add/subtract/accumulate on bfloat16.
// [RULE7] Variable right shift by 4-bit amount, one per integer lane.
// [RULE8] Multiply, add, subtract, and accumulate with a running-sum feedback.
// [RULE9] Integer operands are signed or unsigned by one static setting.
// [RULE10] Packed narrow functions must share one signedness setting.
// [RULE11] Multiplier operands come from the first and second data inputs.
// [RULE12] The adder can be bypassed, giving the raw product as result.
// [RULE13] Synchronous clear zeroes accumulator and result on the next edge.
`timescale 1ns/10ps
module dsp_mac
	import dsp_mac_pkg::*;
(
	input  wire logic              clock_i, // Block clock, 125 MHz.
	input  wire logic              rst_i,   // Asynchronous reset, active high.
	input  wire logic              clear_i, // Synchronous clear of sums.
	input  wire logic              en_i,    // Take operands this cycle.
	input  wire operand_t          opnd_i,  // Operands a, b and addend c.
	output logic                   valid_o, // Result updated, one cycle.
	output logic     [ACC_W-1:0]   result_o, // Registered result.
	input  wire logic [ADDR_W-1:0] addr_i,  // Register byte address.
	input  wire logic [DATA_W-1:0] wdata_i, // Register write data.
	input  wire logic              wr_i,    // Register write strobe.
	input  wire logic              rd_i,    // Register read strobe.
	output logic     [DATA_W-1:0]  rdata_o  // Read data, cycle after rd_i.
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ctrl_t              ctrl_q;
	ctrl_t              ctrl_d;
	logic [DATA_W-1:0]  rdata_q;
	logic [DATA_W-1:0]  rdata_d;
	logic [ACC_W-1:0]   acc_q;
	logic [ACC_W-1:0]   acc_d;
	logic [ACC_W-1:0]   res_q;
	logic [ACC_W-1:0]   res_d;
	logic               valid_q;
	logic               valid_d;
	logic [CNT_W-1:0]   count_q;
	logic [CNT_W-1:0]   count_d;
	logic [ACC_W-1:0]   add_src;
	logic [ACC_W-1:0]   s_sum;
	logic [ACC_W-1:0]   s_res;
	logic [DUAL_RW-1:0] d_sum [2];
	logic [DUAL_RW-1:0] d_res [2];
	logic [QUAD_RW-1:0] q_sum [QUAD_N];
	logic [QUAD_RW-1:0] q_res [QUAD_N];
	logic [BF_W-1:0]    f_res;
	logic [ACC_W-1:0]   lane_sum;
	logic [ACC_W-1:0]   lane_res;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	// Writes land in the control word; read data is held for exactly one
	// cycle and is zero otherwise, including for unmapped offsets.
	always_comb
	begin
		ctrl_d  = ctrl_q;
		rdata_d = '0;
		if (wr_i && addr_i == CTRL_OFS)
		begin
			ctrl_d = ctrl_t'(wdata_i[$bits(ctrl_t)-1:0]);              // [RULE1]
		end
		if (rd_i)
		begin
			case (addr_i)
				CTRL_OFS: rdata_d = DATA_W'(ctrl_q);
				STAT_OFS: rdata_d = {count_q, 14'h0000, ctrl_q.mode};
				RLO_OFS:  rdata_d = res_q[DATA_W-1:0];
				RHI_OFS:  rdata_d = DATA_W'(res_q[ACC_W-1:DATA_W]);
				default:  rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_q  <= CTRL_RST;
			rdata_q <= '0;
		end
		else
		begin
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

	// ----------------------------------------------------------------
	// Addend selection
	// ----------------------------------------------------------------
	// Accumulate feeds back the unshifted running sum; add and subtract
	// use the fabric's third operand. Lanes take their own slices.
	assign add_src = (ctrl_q.op == OP_ACC) ? acc_q : opnd_i.c;       // [RULE8]

	// ----------------------------------------------------------------
	// Integer lanes
	// ----------------------------------------------------------------
	// All lanes share one signedness bit, which is what keeps packed
	// narrow functions consistent with each other. [RULE10]
	dsp_mac_lane #(.AW(A_W), .BW(B_W), .RW(SGL_RW)) u_single (          // [RULE2]
		.a_i      (opnd_i.a),                                          // [RULE11]
		.b_i      (opnd_i.b),                                          // [RULE11]
		.addend_i (add_src),
		.op_i     (ctrl_q.op),
		.signed_i (ctrl_q.sgn),
		.shift_i  (ctrl_q.shift),
		.sum_o    (s_sum),
		.result_o (s_res)
	);

	dsp_mac_lane #(.AW(DA0_W), .BW(DB0_W), .RW(DUAL_RW)) u_dual0 (      // [RULE3]
		.a_i      (opnd_i.a[DA0_W-1:0]),
		.b_i      (opnd_i.b[DB0_W-1:0]),
		.addend_i (add_src[DUAL_RW-1:0]),
		.op_i     (ctrl_q.op),
		.signed_i (ctrl_q.sgn),
		.shift_i  (ctrl_q.shift),
		.sum_o    (d_sum[0]),
		.result_o (d_res[0])
	);

	dsp_mac_lane #(.AW(DA1_W), .BW(DB1_W), .RW(DUAL_RW)) u_dual1 (      // [RULE3]
		.a_i      (opnd_i.a[DA0_W+DA1_W-1:DA0_W]),
		.b_i      (opnd_i.b[DB0_W+DB1_W-1:DB0_W]),
		.addend_i (add_src[2*DUAL_RW-1:DUAL_RW]),
		.op_i     (ctrl_q.op),
		.signed_i (ctrl_q.sgn),
		.shift_i  (ctrl_q.shift),
		.sum_o    (d_sum[1]),
		.result_o (d_res[1])
	);

	// The 7x6 lane keeps only the low 12 product bits.
	dsp_mac_lane #(.AW(QA0_W), .BW(QB0_W), .RW(QUAD_RW)) u_quad0 (      // [RULE4]
		.a_i      (opnd_i.a[QA0_W-1:0]),
		.b_i      (opnd_i.b[QB0_W-1:0]),
		.addend_i (add_src[QUAD_RW-1:0]),
		.op_i     (ctrl_q.op),
		.signed_i (ctrl_q.sgn),
		.shift_i  (ctrl_q.shift),
		.sum_o    (q_sum[0]),
		.result_o (q_res[0])
	);

	// Three 4x4 lanes packed above the 7x6 operands.
	for (genvar i = 1; i < QUAD_N; i++)
	begin : g_quad
		dsp_mac_lane #(.AW(QN_W), .BW(QN_W), .RW(QUAD_RW)) u_quadn (      // [RULE4]
			.a_i      (opnd_i.a[QA0_W+(i-1)*QN_W +: QN_W]),
			.b_i      (opnd_i.b[QB0_W+(i-1)*QN_W +: QN_W]),
			.addend_i (add_src[i*QUAD_RW +: QUAD_RW]),
			.op_i     (ctrl_q.op),
			.signed_i (ctrl_q.sgn),
			.shift_i  (ctrl_q.shift),
			.sum_o    (q_sum[i]),
			.result_o (q_res[i])
		);
	end

	// ----------------------------------------------------------------
	// Floating-point fused multiply-add
	// ----------------------------------------------------------------
	// Subnormals flush to zero and rounding truncates; this trades exact
	// rounding for a short single-cycle path. No NaN is produced.
	logic [BF_W-1:0]   fa, fb, fc;
	logic              p_zero;
	logic              c_zero;
	logic              ps;
	logic [15:0]       mp;
	logic [15:0]       pm;
	logic signed [9:0] pe;
	logic [15:0]       cm;
	logic signed [9:0] ce;
	logic [15:0]       big;
	logic [15:0]       sml;
	logic signed [9:0] big_e;
	logic signed [9:0] diff;
	logic              bs;
	logic              ss;
	logic [15:0]       sml_al;
	logic [16:0]       mag;
	logic              rs;
	logic [4:0]        lead;
	logic [16:0]       norm;
	logic signed [9:0] re;

	always_comb
	begin
		fa     = opnd_i.a[BF_W-1:0];                                     // [RULE11]
		fb     = opnd_i.b[BF_W-1:0];
		fc     = add_src[BF_W-1:0];
		p_zero = (fa[14:7] == 8'h00) || (fb[14:7] == 8'h00);
		c_zero = (fc[14:7] == 8'h00) || (ctrl_q.op == OP_BYPASS);      // [RULE12]
		ps     = fa[15] ^ fb[15] ^ (ctrl_q.op == OP_SUB);               // [RULE6]
		mp     = {1'h1, fa[BF_MAN-1:0]} * {1'h1, fb[BF_MAN-1:0]};
		pe     = 10'({2'h0, fa[14:7]}) + 10'({2'h0, fb[14:7]})
		         - 10'(BF_BIAS) + 10'(mp[15]);
		pm     = mp[15] ? mp : {mp[14:0], 1'h0};
		cm     = {1'h1, fc[BF_MAN-1:0], 8'h00};
		ce     = 10'({2'h0, fc[14:7]});
		// A zero term borrows the other's exponent so alignment is a no-op.
		if (p_zero)
		begin
			pm = '0;
			pe = ce;
		end
		if (c_zero)
		begin
			cm = '0;
			ce = pe;
		end
		if (pe >= ce)
		begin
			big   = pm;
			big_e = pe;
			sml   = cm;
			diff  = pe - ce;
			bs    = ps;
			ss    = fc[15];
		end
		else
		begin
			big   = cm;
			big_e = ce;
			sml   = pm;
			diff  = ce - pe;
			bs    = fc[15];
			ss    = ps;
		end
		sml_al = (diff > 10'sd15) ? '0 : (sml >> diff[3:0]);
		if (bs == ss)
		begin
			mag = {1'h0, big} + {1'h0, sml_al};
			rs  = bs;
		end
		else if (big >= sml_al)
		begin
			mag = {1'h0, big - sml_al};
			rs  = bs;
		end
		else
		begin
			mag = {1'h0, sml_al - big};
			rs  = ss;
		end
		lead = '0;
		for (int k = 0; k < 17; k++)
		begin
			if (mag[k])
			begin
				lead = 5'(k);
			end
		end
		norm = mag << (5'd16 - lead);
		re   = big_e + 10'({5'h00, lead}) - 10'sd15;
		if (mag == '0 || re <= 10'sd0)
		begin
			f_res = '0;
		end
		else if (re >= 10'(BF_EMAX))
		begin
			f_res = {rs, 8'hFF, 7'h00};
		end
		else
		begin
			f_res = {rs, re[7:0], norm[15:9]};                           // [RULE6]
		end
	end

	// ----------------------------------------------------------------
	// Mode selection
	// ----------------------------------------------------------------
	always_comb
	begin
		case (ctrl_q.mode)                                              // [RULE1]
			MODE_SINGLE:
			begin
				lane_sum = s_sum;
				lane_res = s_res;
			end
			MODE_DUAL:
			begin
				lane_sum = {d_sum[1], d_sum[0]};
				lane_res = {d_res[1], d_res[0]};
			end
			MODE_QUAD:
			begin
				lane_sum = {q_sum[3], q_sum[2], q_sum[1], q_sum[0]};
				lane_res = {q_res[3], q_res[2], q_res[1], q_res[0]};
			end
			MODE_FLOAT:
			begin
				lane_sum = ACC_W'(f_res);
				lane_res = ACC_W'(f_res);
			end
			default:
			begin
				lane_sum = '0;
				lane_res = '0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Accumulator and result registers
	// ----------------------------------------------------------------
	// Clear wins over a same-cycle request so a fresh accumulation never
	// starts from a stale sum.
	always_comb
	begin
		acc_d   = acc_q;
		res_d   = res_q;
		count_d = count_q;
		valid_d = 1'h0;
		if (clear_i)
		begin
			acc_d   = '0;                                              // [RULE13]
			res_d   = '0;                                              // [RULE13]
			count_d = '0;
		end
		else if (en_i)
		begin
			acc_d   = lane_sum;                                        // [RULE8]
			res_d   = lane_res;
			count_d = count_q + 16'h0001;
			valid_d = 1'h1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			acc_q   <= '0;
			res_q   <= '0;
			count_q <= '0;
			valid_q <= 1'h0;
		end
		else
		begin
			acc_q   <= acc_d;
			res_q   <= res_d;
			count_q <= count_d;
			valid_q <= valid_d;
		end
	end

	assign result_o = res_q;
	assign valid_o  = valid_q;

endmodule // dsp_mac

// ---- verif/fabric_user.sv ----
// Purpose: Fabric-side user logic that hands operands to the block.
// Assumes: The bench raises go_i for one cycle per request.
// Notes:   Outside a request the operand bus shows inverted stale data.
`timescale 1ns/10ps
module fabric_user
	import dsp_mac_pkg::*;
(
	input  wire logic     clock_i, // Fabric clock.
	input  wire logic     go_i,    // Request from the bench.
	input  wire operand_t val_i,   // Operands for the request.
	output logic          en_o,    // Enable to the block.
	output operand_t      opnd_o   // Operand bus to the block.
);
	operand_t last_q = '0;

	// Keep the last operands so an idle bus never repeats them by luck.
	always @(posedge clock_i)
	begin
		if (go_i)
		begin
			last_q <= val_i;
		end
	end

	// One signedness bit serves every packed lane, so they always agree.
	assign en_o   = go_i;
	assign opnd_o = go_i ? val_i : ~last_q;
endmodule // fabric_user

// ---- verif/dsp_mac_checker.sv ----
// Purpose: Port-level assertions for the multiply-accumulate block.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes:   Result-word read checks only fire when the result is not moving.
`timescale 1ns/10ps
module dsp_mac_checker
	import dsp_mac_pkg::*;
(
	input wire logic              clock_i,  // Block clock.
	input wire logic              rst_i,    // Reset.
	input wire logic              clear_i,  // Clear.
	input wire logic              en_i,     // Request.
	input wire logic              valid_o,  // Result pulse.
	input wire logic [ACC_W-1:0]  result_o, // Result.
	input wire logic [ADDR_W-1:0] addr_i,   // Register address.
	input wire logic [DATA_W-1:0] wdata_i,  // Write data.
	input wire logic              wr_i,     // Write strobe.
	input wire logic              rd_i,     // Read strobe.
	input wire logic [DATA_W-1:0] rdata_o   // Read data.
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	// A request is taken only when clear does not win.
	sequence s_take;
		en_i && !clear_i;
	endsequence
	sequence s_idle;
		!en_i && !clear_i;
	endsequence
	sequence s_float_op;
		(wr_i && addr_i == CTRL_OFS && wdata_i[1:0] == 2'h3) ##1 (!wr_i && en_i && !clear_i);
	endsequence

	AST_VALID_AFTER_TAKE: assert property (s_take |=> valid_o)
		else $error("no result pulse after request");
	AST_VALID_ONLY_TAKE: assert property (!(en_i && !clear_i) |=> !valid_o)
		else $error("result pulse without request");
	AST_CLEAR_ZEROES: assert property (clear_i |=> result_o == '0 && !valid_o)
		else $error("clear did not zero result");
	AST_RESULT_HOLDS: assert property (s_idle |=> $stable(result_o))
		else $error("result moved without request");
	AST_FLOAT_UPPER: assert property (s_float_op |=> result_o[47:16] == '0)
		else $error("float result upper bits set");
	AST_READ_IDLE: assert property (!rd_i |=> rdata_o == '0)
		else $error("read data outside read slot");
	AST_READ_LO: assert property (rd_i && addr_i == RLO_OFS ##0 s_idle
		|=> rdata_o == result_o[31:0])
		else $error("low result word wrong");
	AST_READ_HI: assert property (rd_i && addr_i == RHI_OFS ##0 s_idle
		|=> rdata_o == {16'h0, result_o[47:32]})
		else $error("high result word wrong");
	AST_READ_UNMAPPED: assert property (rd_i && addr_i > RHI_OFS |=> rdata_o == '0)
		else $error("unmapped read not zero");
endmodule // dsp_mac_checker

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the multiply-accumulate block.
// Assumes: Results appear one cycle after a taken request.
// Notes:   Expected values are worked out by hand per lane.
`timescale 1ns/10ps
module tb_top
	import dsp_mac_pkg::*;
;
	logic              clock_i = 1'h0;
	logic              rst_i   = 1'h1;
	logic              clear_i = 1'h0;
	logic              go      = 1'h0;
	logic              wr_i    = 1'h0;
	logic              rd_i    = 1'h0;
	logic [ADDR_W-1:0] addr_i  = 8'h00;
	logic [DATA_W-1:0] wdata_i = 32'h0;
	logic [DATA_W-1:0] rv;
	operand_t          val     = '0;
	operand_t          opnd_i;
	logic              en_i;
	logic              valid_o;
	logic [ACC_W-1:0]  result_o;
	logic [DATA_W-1:0] rdata_o;
	int                num_errors = 0;
	int                n_compared = 0;

	// Half period of 4 ns gives 125 MHz.
	always #4 clock_i = ~clock_i;

	fabric_user i_fabric_user (.clock_i(clock_i), .go_i(go), .val_i(val), .en_o(en_i),
		.opnd_o(opnd_i));
	dsp_mac i_dsp_mac (.clock_i(clock_i), .rst_i(rst_i), .clear_i(clear_i), .en_i(en_i),
		.opnd_i(opnd_i), .valid_o(valid_o), .result_o(result_o), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));

	task automatic chk(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'h1;
		@(posedge clock_i);
		wr_i <= 1'h0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'h1;
		@(posedge clock_i);
		rd_i <= 1'h0;
		#1 d = rdata_o;
	endtask

	// Set the control word, then issue one request right behind it.
	task automatic op(input ctrl_t c, input logic [A_W-1:0] a, input logic [B_W-1:0] b,
		input logic [ACC_W-1:0] d, input logic [ACC_W-1:0] e);
		wr(CTRL_OFS, {23'h0, c});
		go  <= 1'h1;
		val <= '{a: a, b: b, c: d};
		@(posedge clock_i);
		go <= 1'h0;
		#1 chk({47'h0, valid_o}, 48'h1);
		chk(result_o, e);
	endtask

	task automatic t_reset;
		rd(CTRL_OFS, rv);
		chk({16'h0, rv}, {39'h0, CTRL_RST});
		rd(8'h10, rv);
		chk({16'h0, rv}, 48'h0);
		rd(RLO_OFS, rv);
		chk({16'h0, rv}, 48'h0);
		$display("test reset done");
	endtask

	task automatic t_single;
		op('{4'h0, OP_BYPASS, 1'h1, MODE_SINGLE}, 19'h7FFFF, 18'h2, 0, 48'hFFFFFFFFFFFE);
		rd(RHI_OFS, rv);
		chk({16'h0, rv}, 48'hFFFF);
		rd(RLO_OFS, rv);
		chk({16'h0, rv}, 48'hFFFFFFFE);
		op('{4'h0, OP_BYPASS, 1'h0, MODE_SINGLE}, 19'h7FFFF, 18'h3FFFF, 0, 48'h1FFFF40001);
		op('{4'h0, OP_ADD, 1'h1, MODE_SINGLE}, 19'h3, 18'h4, 48'hA, 48'h16);
		op('{4'h0, OP_SUB, 1'h1, MODE_SINGLE}, 19'h3, 18'h4, 48'hA, 48'hFFFFFFFFFFFE);
		op('{4'h0, OP_ACC, 1'h1, MODE_SINGLE}, 19'h3, 18'h4, 0, 48'hA);
		op('{4'h0, OP_ACC, 1'h1, MODE_SINGLE}, 19'h3, 18'h4, 0, 48'h16);
		op('{4'h2, OP_BYPASS, 1'h1, MODE_SINGLE}, 19'h7FFF8, 18'h2, 0, 48'hFFFFFFFFFFFC);
		op('{4'hF, OP_BYPASS, 1'h0, MODE_SINGLE}, 19'h4000, 18'h2, 0, 48'h1);
		$display("test single done");
	endtask

	task automatic t_dual;
		op('{4'h0, OP_BYPASS, 1'h1, MODE_DUAL}, 19'h7F805, 18'hC06, 0, 48'hFFFFFD00001E);
		op('{4'h1, OP_BYPASS, 1'h1, MODE_DUAL}, 19'h7F805, 18'hC06, 0, 48'hFFFFFE00000F);
		op('{4'h0, OP_ADD, 1'h1, MODE_DUAL}, 19'h7F805, 18'hC06, 48'hFFFFFF,
			48'hFFFFFD00001D);
		$display("test dual done");
	endtask

	task automatic t_quad;
		op('{4'h0, OP_BYPASS, 1'h0, MODE_QUAD}, 19'h7FFFF, 18'h3FFFF, 0, 48'h0E10E10E1F41);
		op('{4'h4, OP_BYPASS, 1'h0, MODE_QUAD}, 19'h7FFFF, 18'h3FFFF, 0, 48'h00E00E00E0F4);
		$display("test quad done");
	endtask

	task automatic t_float;
		op('{4'h0, OP_ADD, 1'h1, MODE_FLOAT}, 19'h3F80, 18'h4000, 48'h3F80, 48'h4040);
		op('{4'h0, OP_SUB, 1'h1, MODE_FLOAT}, 19'h3F80, 18'h4000, 48'h3F80, 48'hBF80);
		op('{4'h0, OP_BYPASS, 1'h1, MODE_FLOAT}, 19'h3F80, 18'h4000, 0, 48'h4000);
		op('{4'h0, OP_ACC, 1'h1, MODE_FLOAT}, 19'h3F80, 18'h4000, 0, 48'h4080);
		$display("test float done");
	endtask

	// A request beside a clear is dropped and the running sum restarts.
	task automatic t_clear;
		@(posedge clock_i);
		go      <= 1'h1;
		clear_i <= 1'h1;
		@(posedge clock_i);
		go      <= 1'h0;
		clear_i <= 1'h0;
		#1 chk({47'h0, valid_o}, 48'h0);
		chk(result_o, 48'h0);
		op('{4'h0, OP_ACC, 1'h0, MODE_SINGLE}, 19'h3, 18'h4, 0, 48'hC);
		rd(STAT_OFS, rv);
		chk({16'h0, rv}, 48'h10000);
		$display("test clear done");
	endtask

	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence after five cycles of reset.
	initial
	begin
		repeat (5) @(posedge clock_i);
		rst_i <= 1'h0;
		t_reset();
		t_single();
		t_dual();
		t_quad();
		t_float();
		t_clear();
		give_verdict();
	end

	// Watchdog so a stuck run still reaches the verdict.
	initial
	begin
		repeat (5000) @(posedge clock_i);
		num_errors++;
		$display("MISMATCH t=%0t run did not finish", $time);
		give_verdict();
	end
endmodule // tb_top

bind dsp_mac dsp_mac_checker i_dsp_mac_checker (.clock_i(clock_i), .rst_i(rst_i),
	.clear_i(clear_i), .en_i(en_i), .valid_o(valid_o), .result_o(result_o),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
